/* File: verilog/fmt_regs_pkg.sv */
// Package with register offsets, field positions and reset values of the formatter register bank.
// Summary of operation
// - Enable bit 0 routes index-seen flag to interrupt.
// - Enable bit 1 routes sector-seen flag to interrupt.
// - Enable bit 2 routes input-edge flag to interrupt.
// - Enable bit 3 routes sequencer-halted flag to interrupt.
// - Enable bit 4 routes ECC error flag to interrupt.
// - Enable bit 5 routes transfer-status-edge flag to interrupt.
// - Enable bit 6 routes sequencer-output-edge flag; bit 7 reserved.
// - Chip reset clears whole interrupt enable register.
// - Stack read returns newest pushed byte.
// - Eight-byte ring; each read steps pointer back.
// - Reads never remove data; eight reads wrap.
// - Overflow overwrites oldest; newest eight read newest-first.
// - Address 7FH: read stack, write clock/sync control.
// - Control bits 2..0 pick top N sync bits.
// - Control bit 5 stops buffer clock; test only.
// - Control bits 7..6 pace buffer accesses 4/2/1.
// - Window decode bridges buffer bus, drives strobes; address copies pointer every cycle.
// - Window read captures buffer data into shadow latch.
// - Shadow latch clears on reset or formatter reset.
// - Masked sync match sets flag, gates ECC data.
// - Status read clears all flags except bit 7.
package fmt_regs_pkg;

    localparam logic [7:0] ADDR_READ_CAPTURE  = 8'h4D;
    localparam logic [7:0] ADDR_BUFFER_WINDOW = 8'h70;
    localparam logic [7:0] ADDR_IRQ_STATUS    = 8'h7D;
    localparam logic [7:0] ADDR_IRQ_ENABLE    = 8'h7E;
    localparam logic [7:0] ADDR_STACK_CONTROL = 8'h7F;

    localparam int STACK_DEPTH = 8;
    localparam int FLAG_COUNT  = 7;

    localparam logic [7:0] IRQ_ENABLE_RESET   = 8'h00;
    localparam logic [7:0] IRQ_ENABLE_MASK    = 8'h7F;
    localparam logic [7:0] CLOCK_SYNC_RESET   = 8'h00;
    localparam logic [7:0] READ_CAPTURE_RESET = 8'h00;
    localparam logic [6:0] STATUS_RESET       = 7'h00;

    localparam int SYNC_WIDTH_LSB = 0;
    localparam int BCLK_STOP_BIT  = 5;
    localparam int PACE_LSB       = 6;
    localparam int STATUS_HOST_BIT = 7;

    localparam logic [1:0] PACE_DIV4     = 2'h0;
    localparam logic [1:0] PACE_DIV2     = 2'h1;
    localparam logic [1:0] PACE_DIV1     = 2'h2;
    localparam logic [1:0] PACE_RESERVED = 2'h3;

endpackage

/* File: verilog/formatter_irq_stack_buffer_regs.sv */
// Formatter interrupt enable, capture stack, clock/sync control and buffer access window.
`timescale 1ns/100ps
module formatter_irq_stack_buffer_regs #(
    parameter int DATA_W = 8,
    parameter int ADDR_W = 16
) (
    input  wire logic              clk,
    input  wire logic              rstn,
    input  wire logic              ale,
    input  wire logic              rd_n,
    input  wire logic              wr_n,
    input  wire logic [DATA_W-1:0] ad_in,
    output logic      [DATA_W-1:0] ad_out,
    output logic                   ad_oe,
    output logic                   irq_n,
    input  wire logic              formatter_reset,
    input  wire logic              index_seen_flag_set,
    input  wire logic              sector_seen_flag_set,
    input  wire logic              input_edge_set,
    input  wire logic              seq_halted_set,
    input  wire logic              ecc_error_set,
    input  wire logic              xfer_edge_set,
    input  wire logic              seq_output_edge_set,
    input  wire logic              host_activity,
    input  wire logic              stack_push,
    input  wire logic [DATA_W-1:0] stack_data,
    input  wire logic [DATA_W-1:0] sync_pattern,
    input  wire logic [DATA_W-1:0] deser_byte,
    input  wire logic              deser_valid,
    input  wire logic              read_gate,
    output logic                   sync_detected,
    output logic                   ecc_gate,
    output logic      [DATA_W-1:0] sync_mask,
    output logic                   buffer_clk_en,
    output logic                   buf_access_slot,
    input  wire logic [ADDR_W-1:0] buf_addr_ptr,
    input  wire logic              mem_oe_suppress,
    output logic      [ADDR_W-1:0] buf_addr,
    input  wire logic [DATA_W-1:0] buf_data_in,
    output logic      [DATA_W-1:0] buf_data_out,
    output logic                   buf_data_oe,
    output logic                   mem_output_enable_n,
    output logic                   mem_we_n,
    output logic [6:0]             status_flags
);

    localparam int PTR_W = $clog2(fmt_regs_pkg::STACK_DEPTH);

    // Bus pins come from the microcontroller's timing, so all pass two flip-flops; rd_n and wr_n pass a third for edge detection.
    logic [1:0]        ale_sync_ff;
    logic [2:0]        rd_sync_ff;
    logic [2:0]        wr_sync_ff;
    logic [DATA_W-1:0] ad_meta_ff;
    logic [DATA_W-1:0] ad_sync_ff;

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            ale_sync_ff <= 2'h0;
            rd_sync_ff  <= 3'h7;
            wr_sync_ff  <= 3'h7;
            ad_meta_ff  <= '0;
            ad_sync_ff  <= '0;
        end else begin
            ale_sync_ff <= {ale_sync_ff[0], ale};
            rd_sync_ff  <= {rd_sync_ff[1:0], rd_n};
            wr_sync_ff  <= {wr_sync_ff[1:0], wr_n};
            ad_meta_ff  <= ad_in;
            ad_sync_ff  <= ad_meta_ff;
        end
    end

    logic rd_low;
    logic rd_start;
    logic rd_end;
    logic wr_low;
    logic wr_end;
    assign rd_low   = ~rd_sync_ff[1];
    assign rd_start = rd_sync_ff[2] & ~rd_sync_ff[1];
    assign rd_end   = ~rd_sync_ff[2] & rd_sync_ff[1];
    assign wr_low   = ~wr_sync_ff[1];
    assign wr_end   = ~wr_sync_ff[2] & wr_sync_ff[1];

    // Register state.
    logic [7:0]        addr_ff;
    logic [7:0]        nxt_addr;
    logic [DATA_W-1:0] wdata_ff;
    logic [DATA_W-1:0] nxt_wdata;
    logic [DATA_W-1:0] rdata_ff;
    logic [DATA_W-1:0] nxt_rdata;
    logic              mapped_ff;
    logic              nxt_mapped;
    logic [7:0]        enable_ff;
    logic [7:0]        nxt_enable;
    logic [7:0]        control_ff;
    logic [7:0]        nxt_control;
    logic [6:0]        status_ff;
    logic [6:0]        nxt_status;
    logic [DATA_W-1:0] capture_ff;
    logic [DATA_W-1:0] nxt_capture;
    logic [PTR_W-1:0]  ptr_ff;
    logic [PTR_W-1:0]  nxt_ptr;
    logic [DATA_W-1:0] stack_mem [fmt_regs_pkg::STACK_DEPTH];

    logic [6:0] flag_set;
    logic       hit_window;
    logic       hit_status;
    logic       hit_stack;
    assign flag_set   = {seq_output_edge_set, xfer_edge_set, ecc_error_set, seq_halted_set,
                         input_edge_set, sector_seen_flag_set, index_seen_flag_set};
    assign hit_window = (addr_ff == fmt_regs_pkg::ADDR_BUFFER_WINDOW);
    assign hit_status = (addr_ff == fmt_regs_pkg::ADDR_IRQ_STATUS);
    assign hit_stack  = (addr_ff == fmt_regs_pkg::ADDR_STACK_CONTROL);

    localparam logic [6:0] STATUS_CLEAR_VALUE = fmt_regs_pkg::STATUS_RESET;

    always_comb begin
        nxt_addr    = ale_sync_ff[1] ? ad_sync_ff[7:0] : addr_ff;
        nxt_wdata   = wr_low ? ad_sync_ff : wdata_ff;
        nxt_rdata   = rdata_ff;
        nxt_mapped  = mapped_ff & rd_low;
        nxt_enable  = enable_ff;
        nxt_control = control_ff;
        nxt_status  = status_ff;
        nxt_capture = capture_ff;
        nxt_ptr     = ptr_ff;
        if (rd_start) begin
            nxt_mapped = 1'b1;
            unique case (addr_ff)
                fmt_regs_pkg::ADDR_READ_CAPTURE:  nxt_rdata = capture_ff;
                fmt_regs_pkg::ADDR_BUFFER_WINDOW: nxt_rdata = buf_data_in;
                fmt_regs_pkg::ADDR_IRQ_STATUS:    nxt_rdata = {host_activity, status_ff};
                fmt_regs_pkg::ADDR_IRQ_ENABLE:    nxt_rdata = enable_ff;
                fmt_regs_pkg::ADDR_STACK_CONTROL: nxt_rdata = stack_mem[ptr_ff];
                default: begin
                    nxt_rdata  = '0;
                    nxt_mapped = 1'b0;
                end
            endcase
            if (hit_status) begin
                nxt_status = STATUS_CLEAR_VALUE;
            end
            if (hit_stack) begin
                nxt_ptr = ptr_ff - 1'b1;
            end
        end else if (rd_low && hit_window) begin
            nxt_rdata = buf_data_in;
        end
        if (rd_end && hit_window) begin
            nxt_capture = buf_data_in;
        end
        if (formatter_reset) begin
            nxt_capture = fmt_regs_pkg::READ_CAPTURE_RESET;
            nxt_status  = fmt_regs_pkg::STATUS_RESET;
        end
        // A flag raised in the clearing cycle survives the read.
        nxt_status = nxt_status | flag_set;
        if (wr_end) begin
            if (addr_ff == fmt_regs_pkg::ADDR_IRQ_ENABLE) begin
                nxt_enable = wdata_ff & fmt_regs_pkg::IRQ_ENABLE_MASK;
            end
            if (hit_stack) begin
                nxt_control = wdata_ff;
            end
        end
        // A push always re-aims the pointer at the newest byte.
        if (stack_push) begin
            nxt_ptr = ptr_ff + 1'b1;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            addr_ff    <= 8'h00;
            wdata_ff   <= '0;
            rdata_ff   <= '0;
            mapped_ff  <= 1'b0;
            enable_ff  <= fmt_regs_pkg::IRQ_ENABLE_RESET;
            control_ff <= fmt_regs_pkg::CLOCK_SYNC_RESET;
            status_ff  <= fmt_regs_pkg::STATUS_RESET;
            capture_ff <= fmt_regs_pkg::READ_CAPTURE_RESET;
            ptr_ff     <= '0;
        end else begin
            addr_ff    <= nxt_addr;
            wdata_ff   <= nxt_wdata;
            rdata_ff   <= nxt_rdata;
            mapped_ff  <= nxt_mapped;
            enable_ff  <= nxt_enable;
            control_ff <= nxt_control;
            status_ff  <= nxt_status;
            capture_ff <= nxt_capture;
            ptr_ff     <= nxt_ptr;
        end
    end

    // The ring is plain storage; stale contents after reset are harmless.
    always_ff @(posedge clk) begin
        if (stack_push) begin
            stack_mem[ptr_ff + 1'b1] <= stack_data;
        end
    end

    assign ad_out       = rdata_ff;
    assign ad_oe        = mapped_ff & rd_low;
    assign status_flags = status_ff;

    // Interrupt is a pure function of flags and enables, so it drops as soon as either clears.
    logic [6:0] irq_terms;
    genvar g;
    generate
        for (g = 0; g < fmt_regs_pkg::FLAG_COUNT; g++) begin : g_irq
            assign irq_terms[g] = status_ff[g] & enable_ff[g];
        end
    endgenerate
    assign irq_n = ~|irq_terms;

    // Sync comparison keeps the top N bits, N given by the width field plus one.
    logic [2:0]        sync_width;
    logic [DATA_W-1:0] mask_value;
    assign sync_width = control_ff[fmt_regs_pkg::SYNC_WIDTH_LSB +: 3];
    assign mask_value = {DATA_W{1'b1}} << (3'h7 - sync_width);
    assign sync_mask  = mask_value;

    logic sync_ff;
    logic nxt_sync;
    logic gate_prev_ff;

    always_comb begin
        nxt_sync = sync_ff;
        if (!read_gate) begin
            nxt_sync = 1'b0;
        end else if (deser_valid && ((deser_byte ^ sync_pattern) & mask_value) == '0) begin
            nxt_sync = 1'b1;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            sync_ff      <= 1'b0;
            gate_prev_ff <= 1'b0;
        end else begin
            sync_ff      <= nxt_sync;
            gate_prev_ff <= read_gate;
        end
    end

    assign sync_detected = sync_ff;
    assign ecc_gate      = sync_ff & gate_prev_ff;

    // Access pacing divider; the stop bit freezes it along with the buffer clock.
    logic       bclk_stop;
    logic [1:0] pace_sel;
    logic [1:0] pace_cnt_ff;
    logic [1:0] nxt_pace_cnt;
    logic       slot;
    assign bclk_stop     = control_ff[fmt_regs_pkg::BCLK_STOP_BIT];
    assign pace_sel      = control_ff[fmt_regs_pkg::PACE_LSB +: 2];
    assign buffer_clk_en = ~bclk_stop;

    always_comb begin
        unique case (pace_sel)
            fmt_regs_pkg::PACE_DIV1: slot = 1'b1;
            fmt_regs_pkg::PACE_DIV2: slot = pace_cnt_ff[0];
            fmt_regs_pkg::PACE_DIV4: slot = &pace_cnt_ff;
            fmt_regs_pkg::PACE_RESERVED: slot = &pace_cnt_ff;
        endcase
        nxt_pace_cnt = bclk_stop ? pace_cnt_ff : pace_cnt_ff + 2'h1;
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            pace_cnt_ff <= 2'h0;
        end else begin
            pace_cnt_ff <= nxt_pace_cnt;
        end
    end

    assign buf_access_slot = slot & ~bclk_stop;

    // Buffer window strobes are registered so the memory sees clean edges.
    logic [ADDR_W-1:0] baddr_ff;
    logic [DATA_W-1:0] bdata_ff;
    logic              boe_ff;
    logic              moe_n_ff;
    logic              mwe_n_ff;
    logic              nxt_moe_n;
    logic              nxt_mwe_n;
    logic              nxt_boe;

    always_comb begin
        nxt_moe_n = ~(rd_low & hit_window & ~mem_oe_suppress);
        nxt_mwe_n = ~(wr_low & hit_window);
        nxt_boe   = wr_low & hit_window;
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            baddr_ff <= '0;
            bdata_ff <= '0;
            boe_ff   <= 1'b0;
            moe_n_ff <= 1'b1;
            mwe_n_ff <= 1'b1;
        end else begin
            baddr_ff <= buf_addr_ptr;
            bdata_ff <= ad_sync_ff;
            boe_ff   <= nxt_boe;
            moe_n_ff <= nxt_moe_n;
            mwe_n_ff <= nxt_mwe_n;
        end
    end

    assign buf_addr            = baddr_ff;
    assign buf_data_out        = bdata_ff;
    assign buf_data_oe         = boe_ff;
    assign mem_output_enable_n = moe_n_ff;
    assign mem_we_n            = mwe_n_ff;

endmodule

/* File: testbench/fmt_regs_properties.sv */
// Port-level checker for the formatter register bank.
`timescale 1ns/100ps
module fmt_regs_check #(
    parameter int DATA_W = 8,
    parameter int ADDR_W = 16
) (
    input wire logic              clk,
    input wire logic              rstn,
    input wire logic              rd_n,
    input wire logic              read_gate,
    input wire logic              mem_oe_suppress,
    input wire logic              formatter_reset,
    input wire logic              ad_oe,
    input wire logic              irq_n,
    input wire logic              sync_detected,
    input wire logic              ecc_gate,
    input wire logic [DATA_W-1:0] sync_mask,
    input wire logic              mem_output_enable_n,
    input wire logic              mem_we_n,
    input wire logic              buf_data_oe,
    input wire logic [ADDR_W-1:0] buf_addr_ptr,
    input wire logic [ADDR_W-1:0] buf_addr,
    input wire logic [6:0]        status_flags
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rstn);
    // The first edge in reset only arms the flops, so the check waits for a second one.
    AST_RST_QUIET: assert property (disable iff (1'b0) $past(!rstn) && !rstn |-> irq_n && !ad_oe && mem_we_n)
        else $error("outputs active during reset");
    AST_NO_FLAG_NO_IRQ: assert property (status_flags == 7'h00 |-> irq_n)
        else $error("interrupt without a flag");
    AST_MASK_TOP: assert property (sync_mask[7] && ((~sync_mask & (~sync_mask + 8'h01)) == 8'h00))
        else $error("sync mask not a top-bit run");
    AST_OE_SUPPRESS: assert property ($past(mem_oe_suppress) && mem_oe_suppress |-> mem_output_enable_n)
        else $error("output enable while suppressed");
    AST_ONE_STROBE: assert property (!(!mem_we_n && !mem_output_enable_n))
        else $error("both memory strobes low");
    AST_WE_DRIVES: assert property (!mem_we_n |-> buf_data_oe)
        else $error("write strobe without data drive");
    AST_ADDR_COPY: assert property ($past(rstn) |-> buf_addr == $past(buf_addr_ptr))
        else $error("buffer address not copied");
    AST_ECC_GATE: assert property ($past(rstn) |-> ecc_gate == (sync_detected && $past(read_gate)))
        else $error("ecc gate wrong");
    AST_SYNC_DROP: assert property (!read_gate |=> !sync_detected)
        else $error("sync flag kept without read gate");
    AST_FMT_RESET: assert property (formatter_reset |=> status_flags == 7'h00)
        else $error("flags kept over formatter reset");
    AST_OE_READ: assert property ($rose(ad_oe) |-> !rd_n)
        else $error("bus driven without read");
endmodule
bind formatter_irq_stack_buffer_regs fmt_regs_check #(.DATA_W(DATA_W), .ADDR_W(ADDR_W)) chk_u (
    .clk, .rstn, .rd_n, .read_gate, .mem_oe_suppress, .formatter_reset, .ad_oe, .irq_n,
    .sync_detected, .ecc_gate, .sync_mask, .mem_output_enable_n, .mem_we_n, .buf_data_oe,
    .buf_addr_ptr, .buf_addr, .status_flags);

/* File: testbench/buf_sram_model.sv */
// Buffer memory model on the far side of the access window.
`timescale 1ns/100ps
module buf_sram_model (
    input  wire logic        clk,
    input  wire logic [15:0] buf_addr,
    input  wire logic [7:0]  buf_data_out,
    input  wire logic        mem_output_enable_n,
    input  wire logic        mem_we_n,
    output logic      [7:0]  buf_data_in
);
    logic [7:0] mem [16];
    logic [7:0] last = 8'h00;
    always @(posedge clk) begin
        if (!mem_we_n) begin
            mem[buf_addr[3:0]] <= buf_data_out;
        end
        if (!mem_output_enable_n) begin
            last <= mem[buf_addr[3:0]];
        end
    end
    // A released bus shows the inverse of its last value, so a stale byte never passes.
    assign buf_data_in = !mem_output_enable_n ? mem[buf_addr[3:0]] : ~last;
endmodule

/* File: testbench/testbench.sv */
// Self-checking bench for the formatter register bank.
`timescale 1ns/100ps
module testbench;
    logic        clk = 1'b0;
    logic        rstn = 1'b0;
    logic        ale = 1'b0;
    logic        rd_n = 1'b1;
    logic        wr_n = 1'b1;
    logic        formatter_reset = 1'b0;
    logic        host_activity = 1'b1;
    logic        stack_push = 1'b0;
    logic        deser_valid = 1'b0;
    logic        read_gate = 1'b0;
    logic        mem_oe_suppress = 1'b0;
    logic        seen_oe;
    logic [6:0]  sets = 7'h00;
    logic [7:0]  ad_in = 8'h00;
    logic [7:0]  stack_data = 8'h00;
    logic [7:0]  sync_pattern = 8'hA5;
    logic [7:0]  deser_byte = 8'h00;
    logic [7:0]  d;
    logic [7:0]  en;
    logic [7:0]  cnt;
    logic [2:0]  idx;
    logic        ex;
    logic [15:0] buf_addr_ptr = 16'h0012;
    logic [11:0] rows [9] = '{12'h010, 12'h022, 12'h044, 12'h086, 12'h108, 12'h20A, 12'h40C,
                              12'h777, 12'hFFC};
    int          fail_count = 0;
    int          tests_run = 0;
    wire  [7:0]  ad_out, sync_mask, buf_data_out, buf_data_in;
    wire  [15:0] buf_addr;
    wire  [6:0]  status_flags;
    wire         ad_oe, irq_n, sync_detected, ecc_gate, buffer_clk_en, buf_access_slot;
    wire         buf_data_oe, mem_output_enable_n, mem_we_n;
    formatter_irq_stack_buffer_regs dut_u (
        .clk, .rstn, .ale, .rd_n, .wr_n, .ad_in, .ad_out, .ad_oe, .irq_n, .formatter_reset,
        .index_seen_flag_set(sets[0]), .sector_seen_flag_set(sets[1]), .input_edge_set(sets[2]),
        .seq_halted_set(sets[3]), .ecc_error_set(sets[4]), .xfer_edge_set(sets[5]),
        .seq_output_edge_set(sets[6]), .host_activity, .stack_push, .stack_data, .sync_pattern,
        .deser_byte, .deser_valid, .read_gate, .sync_detected, .ecc_gate, .sync_mask,
        .buffer_clk_en, .buf_access_slot, .buf_addr_ptr, .mem_oe_suppress, .buf_addr,
        .buf_data_in, .buf_data_out, .buf_data_oe, .mem_output_enable_n, .mem_we_n,
        .status_flags);
    buf_sram_model mem_u (
        .clk, .buf_addr, .buf_data_out, .mem_output_enable_n, .mem_we_n, .buf_data_in);
    initial begin
        forever #2 clk = ~clk;
    end
    task automatic cyc(input int n);
        repeat (n) @(negedge clk);
    endtask
    task automatic put_addr(input logic [7:0] a);
        ale = 1'b1;
        ad_in = a;
        cyc(4);
        ale = 1'b0;
        cyc(1);
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        put_addr(a);
        ad_in = v;
        wr_n = 1'b0;
        cyc(7);
        wr_n = 1'b1;
        cyc(6);
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] v);
        put_addr(a);
        rd_n = 1'b0;
        cyc(8);
        v = ad_out;
        seen_oe = ad_oe;
        rd_n = 1'b1;
        cyc(6);
    endtask
    task automatic chk8(input string n, input logic [7:0] e, input logic [7:0] g);
        tests_run++;
        if (g !== e) begin
            fail_count++;
            $display("ERROR %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic report_and_stop;
        $display("Checks %0d mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    initial begin
        #100000;
        fail_count++;
        report_and_stop();
    end
    initial begin
        cyc(16);
        rstn = 1'b1;
        cyc(4);
        for (int r = 0; r < 9; r++) begin
            {en, idx, ex} = rows[r];
            wr(fmt_regs_pkg::ADDR_IRQ_ENABLE, en);
            rd(fmt_regs_pkg::ADDR_IRQ_ENABLE, d);
            chk8("enable", en & 8'h7F, d);
            sets[idx] = 1'b1;
            cyc(1);
            sets = 7'h00;
            cyc(2);
            chk8("irq_n", {7'h00, ex}, {7'h00, irq_n});
            rd(fmt_regs_pkg::ADDR_IRQ_STATUS, d);
            chk8("status", 8'h80 | (8'h01 << idx), d);
            chk8("flags", 8'h00, {1'b0, status_flags});
            chk8("irq_n idle", 8'h01, {7'h00, irq_n});
        end
        $display("Test interrupt rows done");
        for (int j = 0; j < 10; j++) begin
            stack_data = 8'h10 + 8'(j);
            stack_push = 1'b1;
            cyc(1);
            stack_push = 1'b0;
            cyc(1);
        end
        for (int j = 0; j < 9; j++) begin
            rd(fmt_regs_pkg::ADDR_STACK_CONTROL, d);
            chk8("stack", 8'h19 - 8'(j % 8), d);
        end
        $display("Test stack done");
        for (int n = 0; n < 8; n++) begin
            wr(fmt_regs_pkg::ADDR_STACK_CONTROL, 8'(n));
            chk8("mask", 8'hFF << (7 - n), sync_mask);
        end
        // The reserved pacing code is run as the slowest rate.
        for (int p = 0; p < 4; p++) begin
            wr(fmt_regs_pkg::ADDR_STACK_CONTROL, 8'(p) << 6);
            cnt = 8'h00;
            repeat (8) begin
                @(negedge clk);
                cnt = cnt + {7'h00, buf_access_slot};
            end
            chk8("slots", (p == 3) ? 8'h02 : 8'h02 << p, cnt);
        end
        wr(fmt_regs_pkg::ADDR_STACK_CONTROL, 8'h20);
        chk8("bclk stop", 8'h00, {7'h00, buffer_clk_en});
        wr(fmt_regs_pkg::ADDR_STACK_CONTROL, 8'h03);
        chk8("bclk run", 8'h01, {7'h00, buffer_clk_en});
        rd(fmt_regs_pkg::ADDR_STACK_CONTROL, d);
        chk8("stack shared", 8'h18, d);
        chk8("read oe", 8'h01, {7'h00, seen_oe});
        $display("Test control done");
        read_gate = 1'b1;
        deser_byte = 8'hAF;
        deser_valid = 1'b1;
        cyc(1);
        deser_valid = 1'b0;
        cyc(3);
        chk8("sync hit", 8'h03, {6'h00, sync_detected, ecc_gate});
        read_gate = 1'b0;
        cyc(2);
        read_gate = 1'b1;
        deser_byte = 8'h5F;
        deser_valid = 1'b1;
        cyc(1);
        deser_valid = 1'b0;
        cyc(3);
        chk8("sync miss", 8'h00, {7'h00, sync_detected});
        $display("Test sync done");
        buf_addr_ptr = 16'h1234;
        wr(fmt_regs_pkg::ADDR_BUFFER_WINDOW, 8'h3C);
        rd(fmt_regs_pkg::ADDR_BUFFER_WINDOW, d);
        chk8("window", 8'h3C, d);
        rd(fmt_regs_pkg::ADDR_READ_CAPTURE, d);
        chk8("capture", 8'h3C, d);
        mem_oe_suppress = 1'b1;
        rd(fmt_regs_pkg::ADDR_BUFFER_WINDOW, d);
        chk8("switches", 8'hC3, d);
        mem_oe_suppress = 1'b0;
        formatter_reset = 1'b1;
        cyc(2);
        formatter_reset = 1'b0;
        rd(fmt_regs_pkg::ADDR_READ_CAPTURE, d);
        chk8("capture clear", 8'h00, d);
        rd(8'h60, d);
        chk8("unmapped oe", 8'h00, {7'h00, seen_oe});
        $display("Test buffer done");
        rstn = 1'b0;
        cyc(2);
        chk8("irq_n reset", 8'h01, {7'h00, irq_n});
        rstn = 1'b1;
        cyc(4);
        rd(fmt_regs_pkg::ADDR_IRQ_ENABLE, d);
        chk8("enable reset", fmt_regs_pkg::IRQ_ENABLE_RESET, d);
        chk8("mask reset", 8'h80, sync_mask);
        $display("Test reset done");
        report_and_stop();
    end
endmodule
